// ### logic/status_telemetry_bank.sv
`timescale 1ns/100ps

// Functional notes
// - Output undervoltage sets bit 4; others zero
// - Per-page current status byte, resets zero
// - Overcurrent bit 7, undercurrent bit 4
// - Global input status, bits 7 to 4
// - Per-page thermal status, bits 7 to 4
// - Bad command bit 7, bad data 6
// - Packet error sets comm bit 5
// - Protected write or other fault bit 1
// - Sharing bus error sets vendor bit 6
// - Monitor ten-percent warnings set bits 5, 4
// - Sync loss sets vendor bit 3
// - Monitor faults bits 1, 0; 7,2 unused
// - Input, comm, vendor global; others paged
// - Input voltage global linear word
// - Input current global linear word
// - Output voltage unsigned, exponent minus thirteen
// - Output current paged linear word
// - Internal temperature global linear word
// - External temperature paged linear word
// - Third temperature only when config bit 12
// - Third temperature from monitor volts formula
// - Duty cycle paged linear, zero to 100
// - Output overvoltage sets bit 7
// - Summary bit 9 when any global or selected-page status set
module status_telemetry_bank #(
  parameter int PAGES = 2
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_page,
  input wire logic i_read,
  input wire logic [7:0] i_command,
  input wire logic i_clear_faults,
  input wire logic [15:0] i_user_config,
  input wire telemetry_pkg::page_events_t i_page_events [PAGES],
  input wire telemetry_pkg::global_events_t i_global_events,
  input wire telemetry_pkg::global_readings_t i_global_readings,
  input wire telemetry_pkg::page_readings_t i_page_readings [PAGES],
  output logic [15:0] o_read_data,
  output logic o_read_valid,
  output logic o_read_known,
  output logic [15:0] o_summary_word
);
  import telemetry_pkg::*;

  // ----------------------------------------------------------------
  // Event inputs come from analog comparators: two-stage sync
  // ----------------------------------------------------------------
  page_events_t page_sync1 [PAGES];
  page_events_t page_sync2 [PAGES];
  global_events_t glob_sync1;
  global_events_t glob_sync2;
  logic [7:0] stat_vout [PAGES];
  logic [7:0] stat_iout [PAGES];
  logic [7:0] stat_temp [PAGES];
  logic [7:0] stat_input;
  logic [7:0] stat_cml;
  logic [7:0] stat_vendor;
  logic [15:0] next_read_data;
  logic next_known;
  logic any_set;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      glob_sync1 <= '0;
      glob_sync2 <= '0;
    end else if (i_ce) begin
      glob_sync1 <= i_global_events;
      glob_sync2 <= glob_sync1;
    end
  end

  // ----------------------------------------------------------------
  // Per-page sticky status bytes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PAGES; g++) begin : g_page
      logic [7:0] vout_set;
      logic [7:0] iout_set;
      logic [7:0] temp_set;
      assign vout_set = {page_sync2[g].out_ov, 2'b00, page_sync2[g].out_uv, 4'h0};
      assign iout_set = {page_sync2[g].oc, 2'b00, page_sync2[g].uc, 4'h0};
      assign temp_set = {page_sync2[g].thermal, 4'h0};

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          page_sync1[g] <= '0;
          page_sync2[g] <= '0;
        end else if (i_ce) begin
          page_sync1[g] <= i_page_events[g];
          page_sync2[g] <= page_sync1[g];
        end
      end

      // Set wins over a clear arriving in the same cycle
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          stat_vout[g] <= RST_STATUS;
          stat_iout[g] <= RST_STATUS;
          stat_temp[g] <= RST_STATUS;
        end else if (i_ce) begin
          stat_vout[g] <= ((i_clear_faults ? RST_STATUS : stat_vout[g]) | vout_set) & MASK_OUT_VOLT;
          stat_iout[g] <= ((i_clear_faults ? RST_STATUS : stat_iout[g]) | iout_set) & MASK_OUT_CURR;
          stat_temp[g] <= ((i_clear_faults ? RST_STATUS : stat_temp[g]) | temp_set) & MASK_HIGH_NIBBLE;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Global sticky status bytes
  // ----------------------------------------------------------------
  logic [7:0] input_set;
  logic [7:0] cml_set;
  logic [7:0] vendor_set;
  assign input_set = {glob_sync2.input_supply, 4'h0};
  assign cml_set = {glob_sync2.bad_command, glob_sync2.bad_data, glob_sync2.pec_error,
                    3'b000, glob_sync2.other_comm, 1'b0};
  assign vendor_set = {1'b0, glob_sync2.sharing_bus_error,
                       glob_sync2.monitor_uv_warn, glob_sync2.monitor_ov_warn,
                       glob_sync2.sync_loss, 1'b0,
                       glob_sync2.monitor_uv_fault, glob_sync2.monitor_ov_fault};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_input <= RST_STATUS;
      stat_cml <= RST_STATUS;
      stat_vendor <= RST_VENDOR;
    end else if (i_ce) begin
      stat_input <= ((i_clear_faults ? RST_STATUS : stat_input) | input_set) & MASK_HIGH_NIBBLE;
      stat_cml <= ((i_clear_faults ? RST_STATUS : stat_cml) | cml_set) & MASK_CML;
      stat_vendor <= ((i_clear_faults ? RST_STATUS : stat_vendor) | vendor_set) & MASK_VENDOR;
    end
  end

  // ----------------------------------------------------------------
  // Summary word for the selected page
  // ----------------------------------------------------------------
  assign any_set = |{stat_vout[i_page], stat_iout[i_page], stat_temp[i_page],
                     stat_input, stat_cml, stat_vendor};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_summary_word <= '0;
    end else if (i_ce) begin
      o_summary_word <= '0;
      o_summary_word[BIT_SUMMARY_OTHER] <= any_set;
    end
  end

  // ----------------------------------------------------------------
  // Read decode; readings sampled on the read, not continuously
  // ----------------------------------------------------------------
  always_comb begin
    next_read_data = READ_UNMAPPED;
    next_known = 1'b1;
    case (i_command)
      CMD_STATUS_OUTPUT_VOLTAGE: next_read_data = {8'h00, stat_vout[i_page]};
      CMD_STATUS_OUTPUT_CURRENT: next_read_data = {8'h00, stat_iout[i_page]};
      CMD_STATUS_INPUT_SUPPLY: next_read_data = {8'h00, stat_input};
      CMD_STATUS_THERMAL: next_read_data = {8'h00, stat_temp[i_page]};
      CMD_STATUS_COMM_LOGIC: next_read_data = {8'h00, stat_cml};
      CMD_STATUS_VENDOR_MONITOR: next_read_data = {8'h00, stat_vendor};
      CMD_READING_INPUT_VOLTAGE: next_read_data = i_global_readings.input_voltage;
      CMD_READING_INPUT_CURRENT: next_read_data = i_global_readings.input_current;
      CMD_READING_OUTPUT_VOLTAGE: next_read_data = i_page_readings[i_page].output_voltage;
      CMD_READING_OUTPUT_CURRENT: next_read_data = i_page_readings[i_page].output_current;
      CMD_READING_INTERNAL_TEMP: next_read_data = i_global_readings.internal_temp;
      CMD_READING_EXTERNAL_TEMP: next_read_data = i_page_readings[i_page].external_temp;
      CMD_READING_MONITOR_PIN_TEMP: begin
        // The monitor front end applies (V - 0.6)/0.008; only gate it here
        if (i_user_config[BIT_USER_TEMP3]) begin
          next_read_data = i_global_readings.monitor_pin_temp;
        end else begin
          next_known = 1'b0;
        end
      end
      CMD_READING_DUTY_CYCLE: next_read_data = i_page_readings[i_page].duty_cycle;
      default: next_known = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_read_data <= READ_UNMAPPED;
      o_read_valid <= 1'b0;
      o_read_known <= 1'b0;
    end else if (i_ce) begin
      o_read_valid <= i_read;
      if (i_read) begin
        o_read_data <= next_known ? next_read_data : READ_UNMAPPED;
        o_read_known <= next_known;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ov_seen;
    i_ce && page_sync2[0].out_ov;
  endsequence

  property p_vout_ov_sticky;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_ov_seen |=> stat_vout[0][BIT_OUT_OV];
  endproperty
  a_vout_ov_sticky: assert property (p_vout_ov_sticky) else $error("ov bit not set");

  property p_vout_unused_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
      (stat_vout[0] & ~((8'h01 << BIT_OUT_OV) | (8'h01 << BIT_OUT_UV))) == 8'h00;
  endproperty
  a_vout_unused_zero: assert property (p_vout_unused_zero) else $error("vout unused bit set");

  property p_oc_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && page_sync2[1].oc |=> stat_iout[1][BIT_OC];
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("oc bit not set");

  property p_pec_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && glob_sync2.pec_error |=> stat_cml[BIT_CML_PEC];
  endproperty
  a_pec_set: assert property (p_pec_set) else $error("pec bit not set");

  property p_sticky_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
      stat_cml[BIT_CML_CMD] && !i_clear_faults |=> stat_cml[BIT_CML_CMD];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("cml bit lost");

  property p_vendor_unused;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce |=> (stat_vendor & ~MASK_VENDOR) == 8'h00;
  endproperty
  a_vendor_unused: assert property (p_vendor_unused) else $error("vendor unused bit set");

  property p_summary;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && any_set |=> o_summary_word[BIT_SUMMARY_OTHER];
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit missing");

  property p_temp3_gate;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && i_read && i_command == CMD_READING_MONITOR_PIN_TEMP
        && !i_user_config[BIT_USER_TEMP3] |=> !o_read_known && o_read_valid;
  endproperty
  a_temp3_gate: assert property (p_temp3_gate) else $error("temp3 read without config");

  property p_iout_read;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && i_read && i_command == CMD_STATUS_OUTPUT_CURRENT && !i_page
        |=> o_read_data == {8'h00, $past(stat_iout[0])};
  endproperty
  a_iout_read: assert property (p_iout_read) else $error("current status read wrong");

  property p_uv_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && page_sync2[0].out_uv |=> stat_vout[0][BIT_OUT_UV];
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv bit not set");

  property p_uc_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && page_sync2[0].uc |=> stat_iout[0][BIT_UC];
  endproperty
  a_uc_set: assert property (p_uc_set) else $error("uc bit not set");

  // Whole nibble compare, so a swapped field order shows up
  property p_thermal_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce |=> (stat_temp[1] & {$past(page_sync2[1].thermal), 4'h0})
        == {$past(page_sync2[1].thermal), 4'h0};
  endproperty
  a_thermal_set: assert property (p_thermal_set) else $error("thermal bit not set");

  property p_input_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce |=> (stat_input & {$past(glob_sync2.input_supply), 4'h0})
        == {$past(glob_sync2.input_supply), 4'h0};
  endproperty
  a_input_set: assert property (p_input_set) else $error("input status bit not set");

  property p_bad_cmd_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && glob_sync2.bad_command |=> stat_cml[BIT_CML_CMD];
  endproperty
  a_bad_cmd_set: assert property (p_bad_cmd_set) else $error("command bit not set");

  property p_other_comm_set;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && glob_sync2.other_comm |=> stat_cml[BIT_CML_OTHER];
  endproperty
  a_other_comm_set: assert property (p_other_comm_set) else $error("other bit not set");

  // Three enabled edges carry a raw level through both sync stages into the byte
  sequence s_pec_raw_held;
    (i_ce && i_global_events.pec_error) [*3];
  endsequence

  property p_pec_latency;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_pec_raw_held |=> stat_cml[BIT_CML_PEC];
  endproperty
  a_pec_latency: assert property (p_pec_latency) else $error("pec latency exceeded");

  property p_vendor_sticky;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && !i_clear_faults |=> (stat_vendor & $past(stat_vendor & MASK_VENDOR))
        == $past(stat_vendor & MASK_VENDOR);
  endproperty
  a_vendor_sticky: assert property (p_vendor_sticky) else $error("vendor bit lost");

  property p_clear_drops;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && i_clear_faults && !glob_sync2.pec_error |=> !stat_cml[BIT_CML_PEC];
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("pec bit survived clear");

  property p_summary_idle;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && !any_set |=> !o_summary_word[BIT_SUMMARY_OTHER];
  endproperty
  a_summary_idle: assert property (p_summary_idle) else $error("summary bit without cause");

  sequence s_read_taken;
    i_ce && i_read;
  endsequence

  property p_read_answer;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_read_taken |=> o_read_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_input_voltage_read;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_read_taken ##0 i_command == CMD_READING_INPUT_VOLTAGE
        |=> o_read_data == $past(i_global_readings.input_voltage);
  endproperty
  a_input_voltage_read: assert property (p_input_voltage_read) else $error("vin word wrong");

  property p_vout_read;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_read_taken ##0 (i_command == CMD_READING_OUTPUT_VOLTAGE && i_page)
        |=> o_read_data == $past(i_page_readings[1].output_voltage);
  endproperty
  a_vout_read: assert property (p_vout_read) else $error("vout word wrong");

  property p_temp3_read;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_read_taken ##0 (i_command == CMD_READING_MONITOR_PIN_TEMP
        && i_user_config[BIT_USER_TEMP3])
        |=> o_read_known && o_read_data == $past(i_global_readings.monitor_pin_temp);
  endproperty
  a_temp3_read: assert property (p_temp3_read) else $error("temp3 word wrong");

  property p_duty_read;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_read_taken ##0 (i_command == CMD_READING_DUTY_CYCLE && !i_page)
        |=> o_read_data == $past(i_page_readings[0].duty_cycle);
  endproperty
  a_duty_read: assert property (p_duty_read) else $error("duty word wrong");

  property p_input_global;
    @(posedge i_clk) disable iff (!i_arst_n)
      s_read_taken ##0 i_command == CMD_STATUS_INPUT_SUPPLY
        |=> o_read_data == {8'h00, $past(stat_input)};
  endproperty
  a_input_global: assert property (p_input_global) else $error("input status read wrong");

  property p_ce_freeze;
    @(posedge i_clk) disable iff (!i_arst_n)
      !i_ce |=> $stable(stat_cml) && $stable(o_read_valid) && $stable(o_summary_word);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

endmodule // status_telemetry_bank

// ### common/telemetry_pkg.sv
package telemetry_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS_OUTPUT_VOLTAGE = 8'h7A;
  localparam logic [7:0] CMD_STATUS_OUTPUT_CURRENT = 8'h7B;
  localparam logic [7:0] CMD_STATUS_INPUT_SUPPLY = 8'h7C;
  localparam logic [7:0] CMD_STATUS_THERMAL = 8'h7D;
  localparam logic [7:0] CMD_STATUS_COMM_LOGIC = 8'h7E;
  localparam logic [7:0] CMD_STATUS_VENDOR_MONITOR = 8'h80;
  localparam logic [7:0] CMD_READING_INPUT_VOLTAGE = 8'h88;
  localparam logic [7:0] CMD_READING_INPUT_CURRENT = 8'h89;
  localparam logic [7:0] CMD_READING_OUTPUT_VOLTAGE = 8'h8B;
  localparam logic [7:0] CMD_READING_OUTPUT_CURRENT = 8'h8C;
  localparam logic [7:0] CMD_READING_INTERNAL_TEMP = 8'h8D;
  localparam logic [7:0] CMD_READING_EXTERNAL_TEMP = 8'h8E;
  localparam logic [7:0] CMD_READING_MONITOR_PIN_TEMP = 8'h8F;
  localparam logic [7:0] CMD_READING_DUTY_CYCLE = 8'h94;

  // ----------------------------------------------------------------
  // Reset values and bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_VENDOR = 8'h0C;
  localparam int BIT_OUT_OV = 7;
  localparam int BIT_OUT_UV = 4;
  localparam int BIT_OC = 7;
  localparam int BIT_UC = 4;
  localparam int BIT_CML_CMD = 7;
  localparam int BIT_CML_DATA = 6;
  localparam int BIT_CML_PEC = 5;
  localparam int BIT_CML_OTHER = 1;
  localparam int BIT_SUMMARY_OTHER = 9;
  localparam int BIT_USER_TEMP3 = 12;
  localparam logic [7:0] MASK_OUT_VOLT = 8'h90;
  localparam logic [7:0] MASK_OUT_CURR = 8'h90;
  localparam logic [7:0] MASK_HIGH_NIBBLE = 8'hF0;
  localparam logic [7:0] MASK_CML = 8'hE2;
  localparam logic [7:0] MASK_VENDOR = 8'h7B;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out_ov;
    logic out_uv;
    logic oc;
    logic uc;
    logic [3:0] thermal;  // overtemp_fault, ot_warn, ut_warn, undertemp_fault
  } page_events_t;

  typedef struct packed {
    logic [3:0] input_supply;  // ov_fault, ov_warn, uv_warn, uv_fault
    logic bad_command;
    logic bad_data;
    logic pec_error;
    logic other_comm;
    logic sharing_bus_error;
    logic monitor_uv_warn;
    logic monitor_ov_warn;
    logic sync_loss;
    logic monitor_uv_fault;
    logic monitor_ov_fault;
  } global_events_t;

  typedef struct packed {
    logic [4:0] exponent;
    logic [10:0] mantissa;
  } linear11_t;

  typedef struct packed {
    linear11_t input_voltage;
    linear11_t input_current;
    linear11_t internal_temp;
    linear11_t monitor_pin_temp;
  } global_readings_t;

  typedef struct packed {
    logic [15:0] output_voltage;
    linear11_t output_current;
    linear11_t external_temp;
    linear11_t duty_cycle;
  } page_readings_t;

endpackage

// ### dv/host_reader_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Host that issues one read at a time and collects the answer
// ----------------------------------------------------------------
module host_reader_model (
  input wire logic i_clk,
  input wire logic i_read_valid,
  input wire logic [15:0] i_read_data,
  input wire logic i_read_known,
  output logic o_read,
  output logic [7:0] o_command,
  output logic o_page
);
  initial begin
    o_read = 1'b0;
    o_command = 8'h00;
    o_page = 1'b0;
  end

  task automatic read(input logic [7:0] cmd, input logic pg, output logic [15:0] data,
                      output logic known, output logic ok);
    @(posedge i_clk);
    #1;
    o_read = 1'b1;
    o_command = cmd;
    o_page = pg;
    @(posedge i_clk);
    #1;
    o_read = 1'b0;
    // Command is not held after the taking edge, so a stale code must not be trusted
    o_command = ~cmd;
    ok = (i_read_valid === 1'b1);
    data = i_read_data;
    known = i_read_known;
  endtask
endmodule // host_reader_model

// ### dv/pmbus_status_telemetry_bank_tb.sv
`timescale 1ns/100ps

module pmbus_status_telemetry_bank_tb;
  import telemetry_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic [15:0] cfg = 16'h0000;
  page_events_t pev [2];
  global_events_t gev = '0;
  global_readings_t grd = 64'hD1F3_8C22_E0C9_1234;
  page_readings_t prd [2];
  logic rd_req, pg;
  logic [7:0] cmd;
  logic [15:0] rdata, summary;
  logic rvalid, rknown, kn, ok;
  logic [15:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  logic [7:0] g_cmd [14] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h7E, 8'h7E,
                             8'h7E, 8'h7E, 8'h7C, 8'h7C, 8'h7C, 8'h7C};
  logic [7:0] g_exp [14] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h02, 8'h20,
                             8'h40, 8'h80, 8'h10, 8'h20, 8'h40, 8'h80};
  logic [7:0] p_cmd [8] = '{8'h7D, 8'h7D, 8'h7D, 8'h7D, 8'h7B, 8'h7B, 8'h7A, 8'h7A};
  logic [7:0] p_exp [8] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'h10, 8'h80, 8'h10, 8'h80};

  always #20 clk = ~clk;

  status_telemetry_bank status_telemetry_bank_inst (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_page(pg), .i_read(rd_req),
    .i_command(cmd), .i_clear_faults(clr), .i_user_config(cfg),
    .i_page_events(pev), .i_global_events(gev), .i_global_readings(grd),
    .i_page_readings(prd), .o_read_data(rdata), .o_read_valid(rvalid),
    .o_read_known(rknown), .o_summary_word(summary)
  );

  host_reader_model host_reader_model_inst (
    .i_clk(clk), .i_read_valid(rvalid), .i_read_data(rdata), .i_read_known(rknown),
    .o_read(rd_req), .o_command(cmd), .o_page(pg)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] c, input logic p, input logic [15:0] exp,
                        input logic exp_known);
    host_reader_model_inst.read(c, p, rd, kn, ok);
    check({15'h0000, ok}, 16'h0001, "read answer");
    check(rd, exp, "read data");
    check({15'h0000, kn}, {15'h0000, exp_known}, "read known");
  endtask

  task automatic clear_all();
    @(posedge clk);
    #1 clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic summary_chk(input logic exp);
    repeat (2) @(posedge clk);
    #1 check({15'h0000, summary[9]}, {15'h0000, exp}, "summary other");
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    pev[0] = '0;
    pev[1] = '0;
    prd[0] = 64'h1A2B_F00F_C3C4_0064;
    prd[1] = 64'h2B3C_E111_B4B5_8001;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (logic [7:0] c = 8'h7A; c <= 8'h7E; c++) begin
        rd_chk(c, p[0], 16'h0000, 1'b1);
      end
    end
    // Sync-loss flag is set by reset and holds until the host clears it
    rd_chk(8'h80, 1'b0, 16'h0008, 1'b1);
    clear_all();
    rd_chk(8'h80, 1'b0, 16'h0000, 1'b1);
    $display("Test reset values done");
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      #1 gev = global_events_t'(14'h0001 << i);
      repeat (3) @(posedge clk);
      #1 gev = '0;
      repeat (4) @(posedge clk);
      rd_chk(g_cmd[i], 1'b0, {8'h00, g_exp[i]}, 1'b1);
      rd_chk(g_cmd[i], 1'b1, {8'h00, g_exp[i]}, 1'b1);
      summary_chk(1'b1);
      clear_all();
      rd_chk(g_cmd[i], 1'b1, 16'h0000, 1'b1);
      summary_chk(1'b0);
    end
    $display("Test global status done");
    // Events seen while the enable is low are lost, not queued
    ce = 1'b0;
    gev = global_events_t'(14'h0080);
    repeat (6) @(posedge clk);
    #1 gev = '0;
    repeat (3) @(posedge clk);
    #1 ce = 1'b1;
    rd_chk(CMD_STATUS_COMM_LOGIC, 1'b0, 16'h0000, 1'b1);
    // A clear that meets a still-present event leaves the bit set
    gev = global_events_t'(14'h0080);
    repeat (4) @(posedge clk);
    clear_all();
    rd_chk(CMD_STATUS_COMM_LOGIC, 1'b0, 16'h0020, 1'b1);
    @(posedge clk);
    #1 gev = '0;
    repeat (3) @(posedge clk);
    clear_all();
    rd_chk(CMD_STATUS_COMM_LOGIC, 1'b0, 16'h0000, 1'b1);
    $display("Test enable and clear priority done");
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 8; j++) begin
        @(posedge clk);
        #1 pev[p] = page_events_t'(8'h01 << j);
        repeat (3) @(posedge clk);
        #1 pev[p] = '0;
        repeat (4) @(posedge clk);
        rd_chk(p_cmd[j], p[0], {8'h00, p_exp[j]}, 1'b1);
        summary_chk(1'b1);
        rd_chk(p_cmd[j], ~p[0], 16'h0000, 1'b1);
        summary_chk(1'b0);
        clear_all();
      end
    end
    $display("Test paged status done");
    // A reset in mid-run wipes a latched fault
    #1 pev[0] = page_events_t'(8'h20);
    repeat (3) @(posedge clk);
    #1 pev[0] = '0;
    repeat (4) @(posedge clk);
    rd_chk(CMD_STATUS_OUTPUT_CURRENT, 1'b0, 16'h0080, 1'b1);
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    rd_chk(CMD_STATUS_OUTPUT_CURRENT, 1'b0, 16'h0000, 1'b1);
    rd_chk(CMD_STATUS_VENDOR_MONITOR, 1'b0, 16'h0008, 1'b1);
    summary_chk(1'b1);
    clear_all();
    $display("Test mid-run reset done");
    rd_chk(CMD_READING_INPUT_VOLTAGE, 1'b1, grd[63:48], 1'b1);
    rd_chk(CMD_READING_INPUT_CURRENT, 1'b0, grd[47:32], 1'b1);
    rd_chk(CMD_READING_INTERNAL_TEMP, 1'b1, grd[31:16], 1'b1);
    rd_chk(CMD_READING_MONITOR_PIN_TEMP, 1'b0, 16'h0000, 1'b0);
    cfg = 16'h1000;
    rd_chk(CMD_READING_MONITOR_PIN_TEMP, 1'b0, grd[15:0], 1'b1);
    for (int p = 0; p < 2; p++) begin
      rd_chk(CMD_READING_OUTPUT_VOLTAGE, p[0], prd[p][63:48], 1'b1);
      rd_chk(CMD_READING_OUTPUT_CURRENT, p[0], prd[p][47:32], 1'b1);
      rd_chk(CMD_READING_EXTERNAL_TEMP, p[0], prd[p][31:16], 1'b1);
      rd_chk(CMD_READING_DUTY_CYCLE, p[0], prd[p][15:0], 1'b1);
    end
    // An unmapped code answers with an empty word rather than stale data
    rd_chk(8'h95, 1'b0, 16'h0000, 1'b0);
    $display("Test readings done");
    final_report();
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    $display("Watchdog expired at %0t", $time);
    final_report();
  end
endmodule // pmbus_status_telemetry_bank_tb
